// [core/watchdog_interval_timer.sv]
// watchdog and interval timer with password-protected register access
//
// Overview of operation
// - counter and control register take only word writes; byte writes are dropped
// - word write with upper byte 5a at the shared address loads the counter while counting is enabled
// - word write with upper byte a5 at the shared address loads the control register
// - reset control register is written only by a word write at its address
// - a5 with 00 clears watchdog overflow flag once a read of the set flag has armed it, reset bits kept
// - 5a copies data bits 6 and 5 into reset enable and type
// - reads: control at ffbc, counter at ffbd, reset control at ffbf
// - overflow output low 132 states with reset enable, else 130
// - with reset enable, internal reset of chosen type lasts 518 states
// - external reset wins over overflow reset and clears the watchdog flag
// - interval mode with counting raises the interrupt on every overflow
// - interval overflow sets its flag; interrupt follows the flag
// - watchdog overflow sets its flag and drops the output together
// - write and count tick together: written value kept, tick dropped
// - watchdog overflow without reset enable still resets counter and control
// - all timer writes ignored while overflow output is low
// - watchdog flag read while output low does not arm clearing
// - counter clears on reset or whenever counting is disabled
// - three-bit select picks one of eight clock divisions
`timescale 1ns/10ps
module watchdog_interval_timer (
   input wire logic i_clk_sys, // system clock, 20 MHz
   input wire logic i_reset, // external reset pin, asynchronous, active high
   input wire logic [15:0] i_addr, // bus address, low 16 bits
   input wire logic [15:0] i_wdata, // write data, upper byte at [15:8]
   input wire logic i_write, // write strobe, one cycle
   input wire logic i_read, // read strobe, one cycle
   input wire logic i_word, // high for a word access, low for byte
   output logic [7:0] o_rdata, // read data, valid cycle after i_read
   output logic o_interval_interrupt, // interval interrupt request, level
   output logic o_overflow_output_n, // overflow output, active low
   output logic o_chip_reset, // internal chip reset request, level
   output logic o_reset_type_manual // type of chip reset: 1 manual, 0 power-on
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] watchdog_count;
   logic interval_overflow_flag;
   logic next_interval_flag;
   logic timer_mode_select;
   logic count_enable;
   logic [2:0] clock_divisor_select;
   logic watchdog_overflow_flag;
   logic internal_reset_enable;
   logic reset_type_select;

   // clear arming of both flags
   logic ovf_read_armed;
   logic watchdog_overflow_flag_read_armed;

   // count tick and overflow events
   logic count_tick;
   logic overflow;
   logic wd_overflow;
   logic it_overflow;

   // pulse sequencers
   logic [wdt_pkg::PULSE_CNT_W-1:0] out_count;
   logic [wdt_pkg::PULSE_CNT_W-1:0] rst_count;
   wdt_pkg::pulse_state_t out_state;
   wdt_pkg::pulse_state_t rst_state;

   // write decode
   logic write_ok;
   logic wr_count;
   logic wr_control;
   logic wr_clear_watchdog_overflow_flag;
   logic wr_reset_bits;

   // read-back values
   logic [7:0] tcs_value;
   logic [7:0] rcs_value;

   ////////////////////////////////////////////////////////////////////////////
   // write decode
   // word writes only
   assign write_ok = i_write && i_word && o_overflow_output_n;
   assign wr_count = write_ok && i_addr == wdt_pkg::ADDR_TIMER_WRITE
                     && i_wdata[15:8] == wdt_pkg::PASS_COUNT;
   // other upper bytes fall through unmatched
   assign wr_control = write_ok && i_addr == wdt_pkg::ADDR_TIMER_WRITE
                       && i_wdata[15:8] == wdt_pkg::PASS_CONTROL;
   // reset control written only at its address
   // a5 plus 00 clears the flag
   assign wr_clear_watchdog_overflow_flag = write_ok && i_addr == wdt_pkg::ADDR_RESET_WRITE
                          && i_wdata[15:8] == wdt_pkg::PASS_CONTROL
                          && i_wdata[7:0] == wdt_pkg::CLEAR_DATA;
   // 5a writes reset enable and type
   assign wr_reset_bits = write_ok && i_addr == wdt_pkg::ADDR_RESET_WRITE
                          && i_wdata[15:8] == wdt_pkg::PASS_COUNT;

   // overflow is taken when a tick meets the counter at ff with no counter write pending
   assign overflow = count_tick && count_enable && !wr_count && watchdog_count == 8'hff;
   assign wd_overflow = overflow && timer_mode_select;
   assign it_overflow = overflow && !timer_mode_select;

   assign tcs_value = {interval_overflow_flag, timer_mode_select, count_enable,
                       wdt_pkg::TCS_RESERVED_ONES[4:3], clock_divisor_select};
   assign rcs_value = {watchdog_overflow_flag, internal_reset_enable, reset_type_select,
                       wdt_pkg::RCS_RESERVED_ONES[4:0]};

   ////////////////////////////////////////////////////////////////////////////
   // count clock source
   // divisor select picks the rate
   wdt_prescaler u_prescaler (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_run(count_enable),
      .i_select(clock_divisor_select),
      .o_tick(count_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // counter
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         watchdog_count <= wdt_pkg::COUNT_RESET;
      end else if (wd_overflow && !internal_reset_enable) begin
         // timer reset on overflow without chip reset
         watchdog_count <= wdt_pkg::COUNT_RESET;
      end else if (!count_enable) begin
         // held at zero while halted, a counter write included
         watchdog_count <= wdt_pkg::COUNT_RESET;
      end else if (wr_count) begin
         watchdog_count <= i_wdata[7:0];
      end else if (count_tick) begin
         watchdog_count <= watchdog_count + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer control fields; software keeps counting stopped while changing mode or rate
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         timer_mode_select <= 1'b0;
         count_enable <= 1'b0;
         clock_divisor_select <= wdt_pkg::CKS_RESET;
      end else if (wd_overflow && !internal_reset_enable) begin
         // control register back to reset value
         timer_mode_select <= 1'b0;
         count_enable <= 1'b0;
         clock_divisor_select <= wdt_pkg::CKS_RESET;
      end else if (wr_control) begin
         // no interlock; software stops counting first
         timer_mode_select <= i_wdata[wdt_pkg::TCS_MODE_BIT];
         count_enable <= i_wdata[wdt_pkg::TCS_ENABLE_BIT];
         clock_divisor_select <= i_wdata[wdt_pkg::TCS_CKS_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interval overflow flag: read-while-set arms, writing 0 clears, set wins
   always_comb begin
      if (it_overflow) begin
         next_interval_flag = 1'b1;
      end else if (wd_overflow && !internal_reset_enable) begin
         // cleared with the rest of the control register
         next_interval_flag = 1'b0;
      end else if (wr_control && ovf_read_armed && !i_wdata[wdt_pkg::TCS_OVF_BIT]) begin
         // writing 0 clears only after a read that saw the flag at 1
         next_interval_flag = 1'b0;
      end else begin
         next_interval_flag = interval_overflow_flag;
      end
   end

   // flag register; the interrupt output follows the same next value
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         interval_overflow_flag <= 1'b0;
      end else begin
         interval_overflow_flag <= next_interval_flag;
      end
   end

   // a control write always disarms; only a read that sees the flag at 1 arms
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ovf_read_armed <= 1'b0;
      end else if (wr_control) begin
         ovf_read_armed <= 1'b0;
      end else if (i_read && i_addr == wdt_pkg::ADDR_TCS_READ && interval_overflow_flag) begin
         ovf_read_armed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset control register: watchdog overflow flag, set wins over the clear
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         // pin reset wins and clears the flag
         watchdog_overflow_flag <= 1'b0;
      end else if (wd_overflow) begin
         // flag set with the output edge
         watchdog_overflow_flag <= 1'b1;
      end else if (wr_clear_watchdog_overflow_flag && watchdog_overflow_flag_read_armed) begin
         // a5 with 00 clears once a read has armed it
         watchdog_overflow_flag <= 1'b0;
      end
   end

   // reset enable and type survive the internal reset; only the pin or a 5a write clears them
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         internal_reset_enable <= 1'b0;
         reset_type_select <= 1'b0;
      end else if (wr_reset_bits) begin
         internal_reset_enable <= i_wdata[wdt_pkg::RCS_INTERNAL_RESET_ENABLE_BIT];
         reset_type_select <= i_wdata[wdt_pkg::RCS_RESET_TYPE_SELECT_BIT];
      end
   end

   // clearing is armed by reading the flag at 1; either control read address counts
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         watchdog_overflow_flag_read_armed <= 1'b0;
      end else if (wr_clear_watchdog_overflow_flag) begin
         watchdog_overflow_flag_read_armed <= 1'b0;
      end else if (i_read && o_overflow_output_n && watchdog_overflow_flag
                   && (i_addr == wdt_pkg::ADDR_TCS_READ || i_addr == wdt_pkg::ADDR_RCS_READ)) begin
         // a read while the output is low is not recognized
         watchdog_overflow_flag_read_armed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overflow output pulse; length fixed at the overflow instant
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         out_state <= wdt_pkg::PULSE_IDLE;
         out_count <= '0;
         o_overflow_output_n <= 1'b1;
      end else begin
         case (out_state)
            wdt_pkg::PULSE_IDLE: begin
               if (wd_overflow) begin
                  // 132 or 130 states by reset enable
                  out_state <= wdt_pkg::PULSE_ACTIVE;
                  o_overflow_output_n <= 1'b0;
                  out_count <= internal_reset_enable
                     ? wdt_pkg::PULSE_CNT_W'(wdt_pkg::OVF_STATES_INTERNAL_RESET_ENABLE - 1)
                     : wdt_pkg::PULSE_CNT_W'(wdt_pkg::OVF_STATES_NORSTE - 1);
               end
            end
            wdt_pkg::PULSE_ACTIVE: begin
               if (out_count == '0) begin
                  out_state <= wdt_pkg::PULSE_IDLE;
                  o_overflow_output_n <= 1'b1;
               end else begin
                  out_count <= out_count - 1'b1;
               end
            end
            default: begin
               out_state <= wdt_pkg::PULSE_IDLE;
               o_overflow_output_n <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal chip reset pulse; the timer registers survive it, of the two resets only the pin clears them
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         rst_state <= wdt_pkg::PULSE_IDLE;
         rst_count <= '0;
         o_chip_reset <= 1'b0;
      end else begin
         case (rst_state)
            wdt_pkg::PULSE_IDLE: begin
               if (wd_overflow && internal_reset_enable) begin
                  rst_state <= wdt_pkg::PULSE_ACTIVE;
                  o_chip_reset <= 1'b1;
                  rst_count <= wdt_pkg::PULSE_CNT_W'(wdt_pkg::CHIP_RESET_STATES - 1);
               end
            end
            wdt_pkg::PULSE_ACTIVE: begin
               if (rst_count == '0) begin
                  rst_state <= wdt_pkg::PULSE_IDLE;
                  o_chip_reset <= 1'b0;
               end else begin
                  rst_count <= rst_count - 1'b1;
               end
            end
            default: begin
               rst_state <= wdt_pkg::PULSE_IDLE;
               o_chip_reset <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset type latched as the chip reset starts, held after it ends
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_reset_type_manual <= 1'b0;
      end else if (rst_state == wdt_pkg::PULSE_IDLE && wd_overflow
                   && internal_reset_enable) begin
         // power-on or manual by the type bit
         o_reset_type_manual <= reset_type_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request follows the interval flag, dropping in the cycle it clears
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_interval_interrupt <= 1'b0;
      end else begin
         o_interval_interrupt <= next_interval_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port; unmapped addresses read zero
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_read) begin
         case (i_addr)
            wdt_pkg::ADDR_TCS_READ: o_rdata <= tcs_value;
            wdt_pkg::ADDR_COUNT_READ: o_rdata <= watchdog_count;
            wdt_pkg::ADDR_RCS_READ: o_rdata <= rcs_value;
            default: o_rdata <= 8'h00;
         endcase
      end
   end
endmodule // watchdog_interval_timer

// [core/wdt_pkg.sv]
// package: register map, passwords, field positions and timing counts of the watchdog timer
package wdt_pkg;
   // write and read addresses (low 16 bits of the bus address)
   localparam logic [15:0] ADDR_TIMER_WRITE = 16'hffbc;
   localparam logic [15:0] ADDR_TCS_READ = 16'hffbc;
   localparam logic [15:0] ADDR_COUNT_READ = 16'hffbd;
   localparam logic [15:0] ADDR_RESET_WRITE = 16'hffbe;
   localparam logic [15:0] ADDR_RCS_READ = 16'hffbf;
   // write passwords in the upper byte
   localparam logic [7:0] PASS_COUNT = 8'h5a;
   localparam logic [7:0] PASS_CONTROL = 8'ha5;
   localparam logic [7:0] CLEAR_DATA = 8'h00;
   // timer_control_status field positions
   localparam int TCS_OVF_BIT = 7;
   localparam int TCS_MODE_BIT = 6;
   localparam int TCS_ENABLE_BIT = 5;
   localparam int TCS_CKS_MSB = 2;
   // reset_control_status field positions
   localparam int RCS_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
   localparam int RCS_INTERNAL_RESET_ENABLE_BIT = 6;
   localparam int RCS_RESET_TYPE_SELECT_BIT = 5;
   // reserved-bit read patterns and reset values
   localparam logic [7:0] TCS_RESERVED_ONES = 8'h18;
   localparam logic [7:0] RCS_RESERVED_ONES = 8'h1f;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [2:0] CKS_RESET = 3'h0;
   // pulse lengths in states (one state is one system clock)
   localparam int OVF_STATES_INTERNAL_RESET_ENABLE = 132;
   localparam int OVF_STATES_NORSTE = 130;
   localparam int CHIP_RESET_STATES = 518;
   localparam int PULSE_CNT_W = 10;
   // divider
   localparam int PRESCALE_W = 17;
   // pulse sequencer states
   typedef enum logic [1:0] {
      PULSE_IDLE = 2'b00,
      PULSE_ACTIVE = 2'b01
   } pulse_state_t;
endpackage : wdt_pkg

// [core/wdt_prescaler.sv]
// system clock prescaler producing the selected count-clock tick
`timescale 1ns/10ps
module wdt_prescaler (
   input wire logic i_clk_sys, // system clock
   input wire logic i_reset, // asynchronous reset, active high
   input wire logic i_run, // prescaler runs while high, else held at zero
   input wire logic [2:0] i_select, // divisor select
   output logic o_tick // one-cycle tick at the selected rate
);
   logic [wdt_pkg::PRESCALE_W-1:0] div_count;
   logic [wdt_pkg::PRESCALE_W-1:0] prev_count;

   // map the divisor select to the counter bit whose falling edge ticks
   function automatic int tap_of(input logic [2:0] sel);
      case (sel)
         3'h0: tap_of = 0; // clk/2
         3'h1: tap_of = 5; // clk/64
         3'h2: tap_of = 6; // clk/128
         3'h3: tap_of = 8; // clk/512
         3'h4: tap_of = 10; // clk/2048
         3'h5: tap_of = 12; // clk/8192
         3'h6: tap_of = 14; // clk/32768
         default: tap_of = 16; // clk/131072
      endcase
   endfunction

   // free counter, cleared while halted so the first period is whole
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         div_count <= '0;
         prev_count <= '0;
      end else if (!i_run) begin
         div_count <= '0;
         prev_count <= '0;
      end else begin
         div_count <= div_count + 1'b1;
         prev_count <= div_count;
      end
   end

   // tick on the falling edge of the tapped bit
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= i_run && prev_count[tap_of(i_select)] && !div_count[tap_of(i_select)];
      end
   end
endmodule // wdt_prescaler

// [sim/watchdog_interval_timer_bench.sv]
// self-checking bench for the watchdog interval timer
`timescale 1ns/10ps
module watchdog_interval_timer_bench;
   logic i_clk_sys;
   logic i_reset;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic write;
   logic read;
   logic word;
   logic [7:0] rdata;
   logic intr;
   logic ovf_n;
   logic chip_rst;
   logic rst_manual;
   logic [7:0] d;
   int failures;
   int checks_done;
   int lo;
   int hi;
   wdt_cpu_model i_wdt_cpu_model (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_write(write), .o_read(read), .o_word(word));
   watchdog_interval_timer i_watchdog_interval_timer (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_addr(addr), .i_wdata(wdata), .i_write(write), .i_read(read), .i_word(word),
      .o_rdata(rdata), .o_interval_interrupt(intr), .o_overflow_output_n(ovf_n),
      .o_chip_reset(chip_rst), .o_reset_type_manual(rst_manual));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         failures++;
         $display("MISMATCH %0t count got %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      i_wdt_cpu_model.wr(a, v, 1'b1);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      i_wdt_cpu_model.rd(a, d);
      chk8(d, exp);
   endtask
   // bounded wait on the overflow output (w=0) or the interrupt (w=1)
   task automatic wait_sig(input int w, input logic lvl);
      for (int n = 0; n < 2000 && (w == 0 ? ovf_n : intr) !== lvl; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      chk1(w == 0 ? ovf_n : intr, lvl);
   endtask
   // stopped before mode or divisor change
   task automatic arm_watchdog();
      wr(16'hffbc, 16'ha541);
      wr(16'hffbc, 16'ha561);
      wr(16'hffbc, 16'h5aff);
      wait_sig(0, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // clock at 20 mhz
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // a hang is cut short well past the expected run of about a thousand cycles
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      failures++;
      $display("MISMATCH %0t run did not finish", $time);
      end_sim();
   end
   // main sequence
   initial begin
      i_reset = 1'b1;
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge i_clk_sys);
      #1 i_reset = 1'b0;
      rd_chk(16'hffbc, 8'h18);
      rd_chk(16'hffbd, 8'h00);
      rd_chk(16'hffbf, 8'h1f);
      rd_chk(16'hffc0, 8'h00);
      wr(16'hffbc, 16'ha507);
      wr(16'hffbc, 16'ha527);
      rd_chk(16'hffbc, 8'h3f);
      i_wdt_cpu_model.wr(16'hffbc, 16'h5a37, 1'b0);
      rd_chk(16'hffbd, 8'h00);
      wr(16'hffbc, 16'h1237);
      rd_chk(16'hffbd, 8'h00);
      wr(16'hffbc, 16'h5a37);
      rd_chk(16'hffbd, 8'h37);
      wr(16'hffbc, 16'ha507);
      rd_chk(16'hffbd, 8'h00);
      i_wdt_cpu_model.wr(16'hffbe, 16'h5a60, 1'b0);
      rd_chk(16'hffbf, 8'h1f);
      // interval mode: flag, interrupt and clearing
      wr(16'hffbc, 16'ha500);
      wr(16'hffbc, 16'ha520);
      wr(16'hffbc, 16'h5afe);
      wait_sig(1, 1'b1);
      rd_chk(16'hffbc, 8'hb8);
      wr(16'hffbc, 16'ha520);
      wait_sig(1, 1'b0);
      wr(16'hffbc, 16'ha500);
      // watchdog with chip reset of manual type
      wr(16'hffbe, 16'h5a60);
      rd_chk(16'hffbf, 8'h7f);
      wr(16'hffbc, 16'ha561);
      wr(16'hffbc, 16'h5a00);
      rd_chk(16'hffbf, 8'h7f);
      arm_watchdog();
      chk1(rst_manual, 1'b1);
      lo = 0;
      hi = 0;
      repeat (600) begin
         if (ovf_n === 1'b0) lo++;
         if (chip_rst === 1'b1) hi++;
         @(posedge i_clk_sys);
         #1;
      end
      chkn(lo, 132);
      chkn(hi, 518);
      wr(16'hffbc, 16'ha500);
      rd_chk(16'hffbf, 8'hff);
      wr(16'hffbe, 16'ha500);
      rd_chk(16'hffbf, 8'h7f);
      // watchdog without chip reset, writes while the output is low
      wr(16'hffbe, 16'h5a00);
      rd_chk(16'hffbf, 8'h1f);
      arm_watchdog();
      chk1(chip_rst, 1'b0);
      wr(16'hffbe, 16'h5a60);
      rd_chk(16'hffbf, 8'h9f);
      wait_sig(0, 1'b1);
      wr(16'hffbe, 16'ha500);
      rd_chk(16'hffbf, 8'h9f);
      wr(16'hffbe, 16'ha500);
      rd_chk(16'hffbf, 8'h1f);
      rd_chk(16'hffbc, 8'h18);
      rd_chk(16'hffbd, 8'h00);
      // external reset in mid-pulse of a power-on chip reset wins and clears the flag
      wr(16'hffbe, 16'h5a40);
      arm_watchdog();
      chk1(chip_rst, 1'b1);
      chk1(rst_manual, 1'b0);
      i_reset = 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #1 i_reset = 1'b0;
      chk1(ovf_n, 1'b1);
      chk1(chip_rst, 1'b0);
      rd_chk(16'hffbf, 8'h1f);
      end_sim();
   end
endmodule // watchdog_interval_timer_bench
bind watchdog_interval_timer wdt_sva i_wdt_sva (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_word(i_word),
   .o_rdata(o_rdata), .o_interval_interrupt(o_interval_interrupt),
   .o_overflow_output_n(o_overflow_output_n), .o_chip_reset(o_chip_reset),
   .o_reset_type_manual(o_reset_type_manual));

// [sim/wdt_cpu_model.sv]
// bus master model standing in for the supervising cpu
`timescale 1ns/10ps
module wdt_cpu_model (
   input wire logic i_clk_sys, // system clock
   input wire logic [7:0] i_rdata, // read data from the timer
   output logic [15:0] o_addr, // bus address
   output logic [15:0] o_wdata, // write data
   output logic o_write, // write strobe
   output logic o_read, // read strobe
   output logic o_word // word access
);
   // idle bus at time zero
   initial begin
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
      o_write = 1'b0;
      o_read = 1'b0;
      o_word = 1'b0;
   end
   // released lines show the inverse so a stale value never looks valid
   // password word pairing
   task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
      @(posedge i_clk_sys);
      #1;
      o_addr = addr;
      o_wdata = data;
      o_word = word;
      o_write = 1'b1;
      @(posedge i_clk_sys);
      #1;
      o_write = 1'b0;
      o_addr = ~addr;
      o_wdata = ~data;
   endtask
   // read data is registered at the sampling edge, taken just after it
   task automatic rd(input logic [15:0] addr, output logic [7:0] data);
      @(posedge i_clk_sys);
      #1;
      o_addr = addr;
      o_read = 1'b1;
      @(posedge i_clk_sys);
      #1;
      o_read = 1'b0;
      o_addr = ~addr;
      data = i_rdata;
   endtask
endmodule // wdt_cpu_model

// [sim/wdt_sva.sv]
// port-level assertions for the watchdog interval timer
`timescale 1ns/10ps
module wdt_sva (
   input wire logic i_clk_sys, // system clock
   input wire logic i_reset, // asynchronous reset, active high
   input wire logic [15:0] i_addr, // bus address
   input wire logic [15:0] i_wdata, // write data
   input wire logic i_write, // write strobe
   input wire logic i_read, // read strobe
   input wire logic i_word, // word access
   input wire logic [7:0] o_rdata, // read data
   input wire logic o_interval_interrupt, // interval interrupt
   input wire logic o_overflow_output_n, // overflow output, active low
   input wire logic o_chip_reset, // internal chip reset
   input wire logic o_reset_type_manual // chip reset type
);
   int low_cnt;
   int rst_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // run lengths of both pulses, read off at the edge where each one ends
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         low_cnt <= 0;
         rst_cnt <= 0;
      end else begin
         low_cnt <= o_overflow_output_n ? 0 : low_cnt + 1;
         rst_cnt <= o_chip_reset ? rst_cnt + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // register writes that the password lets through, each followed by a read-back
   sequence rcs_set_s;
      i_write && i_word && i_addr == 16'hffbe && i_wdata[15:8] == 8'h5a && o_overflow_output_n;
   endsequence
   sequence tcs_set_s;
      i_write && i_word && i_addr == 16'hffbc && i_wdata[15:8] == 8'ha5 && o_overflow_output_n;
   endsequence
   sequence rcs_read_s;
      i_read && i_addr == 16'hffbf;
   endsequence
   sequence tcs_read_s;
      i_read && i_addr == 16'hffbc;
   endsequence
   ovf_pulse_len_a: assert property (
      $rose(o_overflow_output_n) |-> low_cnt == (o_chip_reset ? 132 : 130))
      else $error("overflow output low for a wrong number of cycles");
   chip_rst_len_a: assert property (
      $fell(o_chip_reset) |-> rst_cnt == 518)
      else $error("chip reset held for a wrong number of cycles");
   rst_with_ovf_a: assert property (
      $rose(o_chip_reset) |-> $fell(o_overflow_output_n))
      else $error("chip reset not started with the overflow output");
   intr_clear_a: assert property (
      $fell(o_interval_interrupt) |-> $past(i_write) || $past(i_write, 2))
      else $error("interrupt dropped without a register write");
   rdata_hold_a: assert property (
      !i_read |=> $stable(o_rdata))
      else $error("read data changed without a read");
   rd_unmapped_a: assert property (
      i_read && !(i_addr inside {16'hffbc, 16'hffbd, 16'hffbf}) |=> o_rdata == 8'h00)
      else $error("unmapped read returned nonzero data");
   rcs_fixed_a: assert property (
      rcs_read_s |=> o_rdata[4:0] == 5'h1f)
      else $error("reset control reserved bits not ones");
   tcs_fixed_a: assert property (
      tcs_read_s |=> o_rdata[4:3] == 2'b11)
      else $error("timer control reserved bits not ones");
   rcs_write_a: assert property (
      rcs_set_s ##2 rcs_read_s |=> o_rdata[6:5] == $past(i_wdata[6:5], 3))
      else $error("reset enable and type not taken from the write");
   tcs_write_a: assert property (
      tcs_set_s ##2 tcs_read_s |=> o_rdata[6:5] == $past(i_wdata[6:5], 3))
      else $error("mode and enable not taken from the write");
endmodule // wdt_sva
